// >>> common/i2cras_map.svh
// Purpose: Constants of the two-wire register access slave.
// Assumes: Included by bare name before the modules that use it.
// Notes:   Timing of the link is set by the master; only encodings live here.
`ifndef I2CRAS_MAP_SVH
`define I2CRAS_MAP_SVH

// Fixed upper part of the 7-bit slave address.
`define I2CRAS_ADDR_PREFIX     5'h0A
// Nonvolatile address value that the configuration store holds after erase.
`define I2CRAS_NV_ADDR_DEFAULT 7'h2C
// Register index of the FIFO window.
`define I2CRAS_FIFO_ADDR       8'h00
// Reserved addresses that are never answered.
`define I2CRAS_GCALL_ADDR      7'h00
`define I2CRAS_DEVID_ADDR      7'h7C
// Rising SCL edges in one byte.
`define I2CRAS_BYTE_BITS       4'h8
// Line levels.
`define I2CRAS_ACK_LEVEL       1'b0
`define I2CRAS_RW_READ         1'b1
// Reset value of the synchronised pins: both lines idle high.
`define I2CRAS_PIN_RST         4'hF

`endif

// >>> common/i2cras_pkg.sv
// Purpose: Types shared by the two-wire register access slave.
// Assumes: Nothing beyond the map header.
// Notes:   States are one-hot.
package i2cras_pkg;

    typedef enum logic [7:0]
    {
        ST_IDLE   = 8'h01,
        ST_ADDR   = 8'h02,
        ST_REG    = 8'h04,
        ST_DATA   = 8'h08,
        ST_ACK    = 8'h10,
        ST_TX     = 8'h20,
        ST_MACK   = 8'h40,
        ST_IGNORE = 8'h80
    } i2cras_state_e;

endpackage

// >>> hdl/i2cras_sync.sv
// Purpose: Two flip-flop synchroniser for asynchronous pins.
// Assumes: Inputs are levels that stay put for several destination cycles.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module i2cras_sync
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// >>> hdl/i2cras_slave.sv
// Purpose: Two-wire slave giving a master access to internal registers and the FIFO.
// Assumes: SCL below 5 MHz, so each SCL phase spans at least 25 mclk cycles.
// Notes:   Received bits are shifted on the SCL clock; the frame engine runs on mclk.
// Contract
// [R1] Bytes travel MSB first, each followed by one acknowledge bit.
// [R2] Transmitter releases SDA at acknowledge; receiver holds it low.
// [R3] After acknowledge, master ends with STOP or a repeated START.
// [R4] Master NACKs the last read byte; slave then releases SDA.
// [R5] First byte after START is the slave address deciding selection.
// [R6] Upper five address bits are fixed at 01010.
// [R7] Low two address bits come from pins or nonvolatile configuration.
// [R8] Write frame: address with write bit, register address, data bytes.
// [R9] Writes to the FIFO address all land in the FIFO.
// [R10] Host sets the read address with a data-less write frame.
// [R11] Address with read bit returns the selected register, then more.
// [R12] Reads advance the register pointer after every byte.
// [R13] Pointer on the FIFO stays put, so reads drain the FIFO.
// [R14] Push-pull link follows fast-mode protocol, at most 5 MBaud.
// [R15] Master drives SCL both ways; slave never stretches the clock.
// [R16] Push-pull link keeps the last SDA level with a keeper.
// [R17] Push-pull address is 01010 plus pin bit with high bit zero, or NV.
// [R18] Master drives SDA high while the push-pull link is idle.
// [R19] In push-pull mode SDA is driven only while SCL is low.
// [R20] Push-pull link is point to point with one slave.
// [R21] Secure key module link always uses the nonvolatile address.
// [R22] START is SDA falling, STOP SDA rising, both with SCL high.
// [R23] Slave only: no clock stretch, no general call, no device ID.
// [R24] Foreign address is not acknowledged; frame ignored until START.
// [R25] Writes to non-FIFO registers advance the pointer after each byte.
`timescale 1ns/1ps
`include "i2cras_map.svh"
module i2cras_slave
    import i2cras_pkg::*;
#(
    parameter logic [7:0] FIFO_ADDR = `I2CRAS_FIFO_ADDR
)
(
    // Core clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Link: SCL as clock and as level, SDA as four signals
    input  wire logic       sclClk,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    output logic            sdaKeep,
    // Configuration
    input  wire logic       pushPull,
    input  wire logic       secureLink,
    input  wire logic       useNvAddr,
    input  wire logic [6:0] nvAddr,
    input  wire logic [1:0] addrSelPin,
    // Internal register port
    output logic      [7:0] regAddr,
    output logic            regWrEn,
    output logic      [7:0] regWrData,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData,
    // Status
    output logic            busy
);

    // The FIFO window is the one address that never advances.
    function automatic logic [7:0] nextPtr(input logic [7:0] p);
        nextPtr = (p == FIFO_ADDR) ? p : p + 8'h01; // [R12] [R13] [R9] [R25]
    endfunction

    // Reserved addresses are refused even if the configuration names them.
    function automatic logic addrHit(input logic [6:0] a, input logic [6:0] own);
        addrHit = (a == own) && (a != `I2CRAS_GCALL_ADDR) && (a != `I2CRAS_DEVID_ADDR); // [R23] [R24]
    endfunction

    i2cras_state_e state;
    i2cras_state_e ackNext;

    logic [3:0] pinS;
    logic       sclS;
    logic       sdaS;
    logic [1:0] selS;
    logic       sclP;
    logic       sdaP;
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic [3:0] bitCnt;
    logic       byteDone;
    logic       countRise;
    logic [7:0] rxShift;
    logic [7:0] rxByte;
    logic [6:0] ownAddr;
    logic [6:0] next_ownAddr;
    logic [7:0] ptr;
    logic [7:0] txByte;
    logic [7:0] txShift;
    logic       rdTake;
    logic       own;
    logic       bitVal;

    // Link domain: bits are shifted in on the master's own rising SCL edge.
    // The register needs no reset, the engine only reads it after eight rises.
    always_ff @(posedge sclClk)
    begin
        rxShift <= {rxShift[6:0], sdaIn}; // [R1]
    end

    // Read only at a byte boundary, when the last rise is at least a
    // half SCL period old and the next is one low phase less the synchroniser delay away.
    assign rxByte = rxShift;

    i2cras_sync
    #(
        .W       (4),
        .RST_VAL (`I2CRAS_PIN_RST)
    )
    u_pinSync
    (
        .clk   (mclk),
        .rst_n (rst_n),
        .d     ({sclIn, sdaIn, addrSelPin}),
        .q     (pinS)
    );

    assign sclS = pinS[3];
    assign sdaS = pinS[2];
    assign selS = pinS[1:0];

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sclP <= 1'b1;
            sdaP <= 1'b1;
        end
        else
        begin
            sclP <= sclS;
            sdaP <= sdaS;
        end
    end

    assign sclRise   = sclS && !sclP; // [R14]
    assign sclFall   = !sclS && sclP;
    assign startCond = sclS && sclP && sdaP && !sdaS; // [R22]
    assign stopCond  = sclS && sclP && !sdaP && sdaS; // [R22]

    // Address selection.
    always_comb
    begin
        if (secureLink)
        begin
            next_ownAddr = nvAddr; // [R21]
        end
        else if (useNvAddr)
        begin
            next_ownAddr = {`I2CRAS_ADDR_PREFIX, nvAddr[1:0]}; // [R7] [R17]
        end
        else if (pushPull)
        begin
            next_ownAddr = {`I2CRAS_ADDR_PREFIX, 1'b0, selS[0]}; // [R17]
        end
        else
        begin
            next_ownAddr = {`I2CRAS_ADDR_PREFIX, selS}; // [R6] [R7]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ownAddr <= `I2CRAS_NV_ADDR_DEFAULT;
        end
        else
        begin
            ownAddr <= next_ownAddr;
        end
    end

    // Bit counting: rises are counted only while a byte is on the wire.
    assign countRise = (state == ST_ADDR) || (state == ST_REG) || (state == ST_DATA) || (state == ST_TX);
    assign byteDone  = sclFall && (bitCnt == `I2CRAS_BYTE_BITS);

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            bitCnt <= 4'h0;
        end
        else if (startCond || byteDone)
        begin
            bitCnt <= 4'h0;
        end
        else if (sclRise && countRise)
        begin
            bitCnt <= bitCnt + 4'h1; // [R1]
        end
    end

    // Read data is expected one cycle after the strobe.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rdTake <= 1'b0;
            txByte <= 8'h00;
        end
        else
        begin
            rdTake <= regRdEn;
            if (rdTake)
            begin
                txByte <= regRdData; // [R11]
            end
        end
    end

    // Frame engine.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state     <= ST_IDLE;
            ackNext   <= ST_IDLE;
            ptr       <= 8'h00;
            own       <= 1'b0;
            bitVal    <= 1'b1;
            txShift   <= 8'h00;
            regAddr   <= 8'h00;
            regWrData <= 8'h00;
            regWrEn   <= 1'b0;
            regRdEn   <= 1'b0;
        end
        else
        begin
            regWrEn <= 1'b0;
            regRdEn <= 1'b0;
            if (startCond)
            begin
                state <= ST_ADDR; // [R5] [R22]
                own   <= 1'b0;
            end
            else if (stopCond)
            begin
                state <= ST_IDLE;
                own   <= 1'b0;
            end
            else
            begin
                unique case (state)
                    ST_IDLE, ST_IGNORE:
                    begin
                        own <= 1'b0;
                    end
                    ST_ADDR:
                    begin
                        if (byteDone)
                        begin
                            if (addrHit(rxByte[7:1], ownAddr)) // [R5] [R24]
                            begin
                                own    <= 1'b1;
                                bitVal <= `I2CRAS_ACK_LEVEL; // [R2]
                                state  <= ST_ACK;
                                if (rxByte[0] == `I2CRAS_RW_READ)
                                begin
                                    regAddr <= ptr; // [R11]
                                    regRdEn <= 1'b1;
                                    ptr     <= nextPtr(ptr); // [R12] [R13]
                                    ackNext <= ST_TX;
                                end
                                else
                                begin
                                    ackNext <= ST_REG; // [R8]
                                end
                            end
                            else
                            begin
                                state <= ST_IGNORE; // [R24]
                            end
                        end
                    end
                    ST_REG:
                    begin
                        if (byteDone)
                        begin
                            ptr     <= rxByte; // [R8] [R10]
                            own     <= 1'b1;
                            bitVal  <= `I2CRAS_ACK_LEVEL; // [R2]
                            ackNext <= ST_DATA;
                            state   <= ST_ACK;
                        end
                    end
                    ST_DATA:
                    begin
                        if (byteDone)
                        begin
                            regAddr   <= ptr;
                            regWrData <= rxByte; // [R8]
                            regWrEn   <= 1'b1;
                            ptr       <= nextPtr(ptr); // [R9] [R25]
                            own       <= 1'b1;
                            bitVal    <= `I2CRAS_ACK_LEVEL; // [R2]
                            ackNext   <= ST_DATA;
                            state     <= ST_ACK;
                        end
                    end
                    ST_ACK:
                    begin
                        if (sclFall)
                        begin
                            state <= ackNext;
                            if (ackNext == ST_TX)
                            begin
                                own     <= 1'b1;
                                bitVal  <= txByte[7]; // [R1]
                                txShift <= {txByte[6:0], 1'b0};
                            end
                            else
                            begin
                                own <= 1'b0;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (byteDone)
                        begin
                            own   <= 1'b0; // [R2]
                            state <= ST_MACK;
                        end
                        else if (sclFall)
                        begin
                            bitVal  <= txShift[7]; // [R1]
                            txShift <= {txShift[6:0], 1'b0};
                        end
                    end
                    ST_MACK:
                    begin
                        if (sclRise)
                        begin
                            if (sdaS == `I2CRAS_ACK_LEVEL)
                            begin
                                regAddr <= ptr; // [R11] [R12]
                                regRdEn <= 1'b1;
                                ptr     <= nextPtr(ptr); // [R13]
                            end
                            else
                            begin
                                // The line stays released so the master can end the frame.
                                state <= ST_IGNORE; // [R4]
                            end
                        end
                        else if (sclFall)
                        begin
                            own     <= 1'b1;
                            bitVal  <= txByte[7];
                            txShift <= {txByte[6:0], 1'b0};
                            state   <= ST_TX;
                        end
                    end
                endcase
            end
        end
    end

    // Pin stage. In push-pull mode both levels are driven, but only while
    // SCL is low; the keeper holds the line across the high phase. The
    // release follows the rise by the synchroniser delay plus one register cycle, well inside the
    // master's high time, and SCL itself is never driven.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sdaOe  <= 1'b0;
            sdaOut <= 1'b0;
        end
        else if (pushPull)
        begin
            sdaOe  <= own && !sclS; // [R19] [R15] [R20]
            sdaOut <= bitVal;
        end
        else
        begin
            sdaOe  <= own && !bitVal; // [R2] [R23]
            sdaOut <= 1'b0;
        end
    end

    // Keeper level: the last level seen on SDA, applied while nobody drives.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sdaKeep <= 1'b1;
        end
        else
        begin
            sdaKeep <= sdaS; // [R16]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= (state != ST_IDLE);
        end
    end

endmodule

// >>> verif/i2cras_slave_sva.sv
// Purpose: Port assertions of the two-wire register access slave.
// Assumes: SCL phases span at least 25 mclk cycles.
// Notes:   Windows allow for the two-flop pin synchronisers.
`timescale 1ns/1ps
module i2cras_slave_sva
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic sdaKeep,
    input wire logic pushPull,
    // Register port and status
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_od_low_only: assert property (!pushPull && sdaOe |-> !sdaOut)
        else $error("open-drain SDA driven high");
    a_ack_hold: assert property (!pushPull && sdaOe && sclIn |=> sdaOe)
        else $error("SDA drive dropped while SCL high");
    a_ack_after_wr: assert property (regWrEn |-> ##[1:8] sdaOe)
        else $error("stored byte not acknowledged");
    a_strobe_single: assert property ((regWrEn || regRdEn) |=> !(regWrEn || regRdEn) [*8])
        else $error("register strobes too close");
    a_strobe_framed: assert property ((regWrEn || regRdEn) |-> busy)
        else $error("register strobe outside a frame");
    a_start_busy: assert property ($fell(sdaIn) && sclIn |-> ##[1:5] busy)
        else $error("START not seen");
    a_stop_idle: assert property ($rose(sdaIn) && sclIn |-> ##[1:5] !busy)
        else $error("STOP not seen");
    a_pp_release: assert property (pushPull && $rose(sclIn) |-> ##[1:6] !sdaOe)
        else $error("SDA driven while SCL high");
    a_keeper_follows: assert property ($stable(sdaIn) [*4] |-> sdaKeep == sdaIn)
        else $error("keeper lost the SDA level");
    a_idle_quiet: assert property (!busy |-> !sdaOe)
        else $error("SDA driven outside a frame");
endmodule

bind i2cras_slave i2cras_slave_sva u_sva
(
    .mclk     (mclk),
    .rst_n    (rst_n),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .sdaKeep  (sdaKeep),
    .pushPull (pushPull),
    .regWrEn  (regWrEn),
    .regRdEn  (regRdEn),
    .busy     (busy)
);

// >>> verif/i2cras_master.sv
// Purpose: Behavioural two-wire master pacing the link from its own clock.
// Assumes: Four link clocks per SCL phase give 120 ns, inside the 5 MHz limit.
// Notes:   In push-pull mode data bits are released while SCL is high.
`timescale 1ns/1ps
module i2cras_master
(
    // Link clock and mode
    input  wire logic lclk,
    input  wire logic pushPull,
    // Link pins
    input  wire logic sda,
    output logic      scl,
    output logic      mOut,
    output logic      mOe
);
    initial
    begin
        scl  = 1'b1;
        mOut = 1'b1;
        mOe  = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge lclk);
        #1;
    endtask

    // Also serves as repeated START.
    task automatic startCond();
        tick(1);
        mOe  = 1'b1;
        mOut = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(4);
        mOut = 1'b0;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stopCond();
        tick(1);
        mOe  = 1'b1;
        mOut = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(4);
        mOut = 1'b1;
        tick(8);
    endtask

    // Data changes only in the low phase, one link clock after the fall.
    task automatic bitSlot(input logic d, input logic drv, output logic q);
        tick(1);
        mOe  = drv;
        mOut = d;
        tick(3);
        scl = 1'b1;
        if (pushPull)
            mOe = 1'b0;
        tick(2);
        q = sda;
        tick(2);
        scl = 1'b0;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--)
            bitSlot(b[i], 1'b1, q);
        bitSlot(1'b1, 1'b0, ack);
    endtask

    task automatic recvByte(output logic [7:0] b, input logic nack);
        logic q;
        for (int i = 7; i >= 0; i--)
        begin
            bitSlot(1'b1, 1'b0, q);
            b[i] = q;
        end
        bitSlot(nack, 1'b1, q);
    endtask
endmodule

// >>> verif/tb_top.sv
// Purpose: Self-checking bench of the two-wire register access slave.
// Assumes: Register reads return the address XOR A5 one cycle later.
// Notes:   Register strobes are matched against a queue of expected accesses.
`timescale 1ns/1ps
`include "i2cras_map.svh"
module tb_top;
    logic        mclk;
    logic        lclk;
    logic        rst_n;
    logic        pushPull;
    logic        secureLink;
    logic        useNvAddr;
    logic [6:0]  nvAddr;
    logic [1:0]  addrSelPin;
    logic [7:0]  regRdData;
    logic [7:0]  regAddr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    logic        regRdEn;
    logic        busy;
    logic        sdaOut;
    logic        sdaOe;
    logic        sdaKeep;
    logic        scl;
    logic        mOut;
    logic        mOe;
    logic        ack;
    logic [6:0]  me;
    logic [6:0]  good;
    logic [6:0]  bad;
    logic [7:0]  rv;
    logic [16:0] exp;
    logic [16:0] expQ[$];
    logic [31:0] seed = 32'h0000CCD8;
    int          errors;
    int          cmpCount;
    wire         sda;

    // Push-pull contention shows as unknown; a released push-pull line takes the keeper.
    assign sda = (pushPull && mOe && sdaOe && mOut !== sdaOut) ? 1'bx :
                 ((mOe && !mOut) || (sdaOe && !sdaOut)) ? 1'b0 :
                 (mOe || sdaOe || !pushPull) ? 1'b1 : sdaKeep;

    i2cras_slave u_dut
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .sclClk     (scl),
        .sclIn      (scl),
        .sdaIn      (sda),
        .sdaOut     (sdaOut),
        .sdaOe      (sdaOe),
        .sdaKeep    (sdaKeep),
        .pushPull   (pushPull),
        .secureLink (secureLink),
        .useNvAddr  (useNvAddr),
        .nvAddr     (nvAddr),
        .addrSelPin (addrSelPin),
        .regAddr    (regAddr),
        .regWrEn    (regWrEn),
        .regWrData  (regWrData),
        .regRdEn    (regRdEn),
        .regRdData  (regRdData),
        .busy       (busy)
    );

    i2cras_master u_master
    (
        .lclk     (lclk),
        .pushPull (pushPull),
        .sda      (sda),
        .scl      (scl),
        .mOut     (mOut),
        .mOe      (mOe)
    );

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        lclk = 1'b0;
        #7;
        forever #15 lclk = ~lclk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic check(input string nm, input logic [16:0] e, input logic [16:0] s);
        cmpCount++;
        if (s !== e)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    always @(posedge mclk)
    begin
        if (rst_n && (regWrEn || regRdEn))
        begin
            exp = (expQ.size() != 0) ? expQ.pop_front() : 17'h1FFFF;
            check("strobe", exp, {regWrEn, regAddr, regWrEn ? regWrData : 8'h00});
        end
        regRdData <= #1 regAddr ^ 8'hA5;
    end

    // A push-pull NACK leaves the keeper level, so only acknowledges are checked there.
    task automatic sendChk(input logic [7:0] b, input logic e);
        u_master.sendByte(b, ack);
        if (!(pushPull && e))
            check("ack", {16'h0000, e}, {16'h0000, ack});
    endtask

    task automatic wrFrame(input logic [6:0] a, input logic [7:0] r, input int n, input logic ok,
                           input logic stp);
        logic [7:0] d;
        u_master.startCond();
        sendChk({a, 1'b0}, !ok);
        sendChk(r, !ok);
        for (int i = 0; i < n; i++)
        begin
            d = rnd();
            expQ.push_back({1'b1, r, d});
            sendChk(d, 1'b0);
            if (r != `I2CRAS_FIFO_ADDR)
                r++;
        end
        if (stp)
            u_master.stopCond();
    endtask

    task automatic rdFrame(input logic [6:0] a, input logic [7:0] r, input int n);
        logic [7:0] d;
        logic [7:0] p;
        wrFrame(a, r, 0, 1'b1, 1'b0);
        p = r;
        for (int i = 0; i < n; i++)
        begin
            expQ.push_back({1'b0, p, 8'h00});
            if (p != `I2CRAS_FIFO_ADDR)
                p++;
        end
        u_master.startCond();
        sendChk({a, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            u_master.recvByte(d, i == n - 1);
            check("rdata", {9'h000, r ^ 8'hA5}, {9'h000, d});
            if (r != `I2CRAS_FIFO_ADDR)
                r++;
        end
        // Look after the slave has had time to react to the falling SCL edge.
        repeat (8) @(posedge mclk);
        #1;
        check("release", 17'h00000, {16'h0000, sdaOe});
        u_master.stopCond();
    endtask

    task automatic endTest(input string nm);
        repeat (50) @(posedge mclk);
        check("pending", 17'h00000, 17'(expQ.size()));
        $display("test %s done", nm);
    endtask

    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #300000;
        errors++;
        $display("watchdog expired");
        stopTest();
    end

    initial
    begin
        errors     = 0;
        cmpCount   = 0;
        rst_n      = 1'b0;
        pushPull   = 1'b0;
        secureLink = 1'b0;
        useNvAddr  = 1'b0;
        nvAddr     = `I2CRAS_NV_ADDR_DEFAULT;
        addrSelPin = 2'b00;
        repeat (10) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        check("idle", 17'h00000, {14'h0000, busy, sdaOe, regWrEn});
        me = {`I2CRAS_ADDR_PREFIX, 2'b00};
        wrFrame(me, 8'h10, 3, 1'b1, 1'b1);
        wrFrame(me, `I2CRAS_FIFO_ADDR, 3, 1'b1, 1'b1);
        endTest("write");
        rdFrame(me, 8'h10, 3);
        rdFrame(me, `I2CRAS_FIFO_ADDR, 2);
        endTest("read");
        wrFrame(`I2CRAS_GCALL_ADDR, 8'h10, 0, 1'b0, 1'b1);
        wrFrame(me ^ 7'h40, 8'h10, 0, 1'b0, 1'b1);
        endTest("foreign");
        for (int k = 0; k < 4; k++)
        begin
            rv   = rnd();
            good = {`I2CRAS_ADDR_PREFIX, rv[1:0]};
            bad  = {`I2CRAS_ADDR_PREFIX, ~rv[1:0]};
            if (k == 1)
            begin
                good = bad;
                bad  = {`I2CRAS_ADDR_PREFIX, rv[1:0]};
            end
            if (k == 2)
            begin
                good[1] = 1'b0;
                bad     = good | 7'h02;
            end
            if (k == 3)
            begin
                good = `I2CRAS_NV_ADDR_DEFAULT;
                bad  = {`I2CRAS_ADDR_PREFIX, 2'b01};
            end
            @(posedge mclk);
            #1;
            pushPull   = k >= 2;
            secureLink = k == 3;
            useNvAddr  = k == 1;
            nvAddr     = (k == 1) ? good : `I2CRAS_NV_ADDR_DEFAULT;
            addrSelPin = rv[1:0];
            repeat (10) @(posedge mclk);
            wrFrame(good, rnd(), 1, 1'b1, 1'b1);
            wrFrame(bad, 8'h20, 0, 1'b0, 1'b1);
            rdFrame(good, rnd(), 2);
            endTest("mode");
        end
        stopTest();
    end
endmodule
